// *** logic/wdg_pkg.sv ***
package wdg_pkg;

  // ************************************************************
  // register map (byte offsets)
  // ************************************************************
  localparam logic [11:0] WDG_OFF_UNLOCK = 12'h040;
  localparam logic [11:0] WDG_OFF_ENABLE = 12'h044;
  localparam logic [11:0] WDG_OFF_CLEAR = 12'h048;
  localparam logic [11:0] WDG_OFF_STATUS = 12'h04C;
  localparam logic [11:0] WDG_OFF_INT_STS = 12'h050;
  localparam logic [11:0] WDG_OFF_INT_MASK = 12'h054;

  // ************************************************************
  // keys, field positions, reset values
  // ************************************************************
  localparam logic [31:0] WDG_UNLOCK_KEY = 32'hAA55_55AA;
  localparam logic [31:0] WDG_CLEAR_KEY = 32'h55AA_AA55;
  localparam int WDG_UNLOCK_BIT = 0;
  localparam int WDG_RUN_BIT = 0;
  localparam int WDG_SEL_LSB = 2;
  localparam int WDG_FLAG_BIT = 7;
  localparam int WDG_MODE_BIT = 24;
  localparam logic WDG_RUN_RST = 1'b1;
  localparam logic [1:0] WDG_SEL_RST = 2'h0;
  localparam logic WDG_MODE_RST = 1'b1;
  localparam logic [15:0] WDG_COUNT_RST = 16'h0000;

  // ************************************************************
  // interrupt sources
  // ************************************************************
  localparam int WDG_IRQ_W = 3;
  localparam int WDG_IRQ_FIRE = 0;
  localparam int WDG_IRQ_KICK = 1;
  localparam int WDG_IRQ_REJECT = 2;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int WDG_SYS_CLK_HZ = 100_000_000;
  // counter runs on the low speed clock divided by 16, so 16 s fits 16 bits
  localparam int WDG_COUNT_RATE_HZ = 2048;
  localparam int WDG_TICK_DIV = WDG_SYS_CLK_HZ / WDG_COUNT_RATE_HZ;
  localparam int WDG_PERIOD_BASE_SEC = 2;
  localparam int WDG_RST_PULSE_CYCLES = 16;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [4:0] {
    WDG_PM_WORK = 5'b00001,
    WDG_PM_IDLE = 5'b00010,
    WDG_PM_SLEEP = 5'b00100,
    WDG_PM_DEEP = 5'b01000,
    WDG_PM_RTC_ONLY = 5'b10000
  } wdg_power_t;

  typedef enum logic [2:0] {
    WDG_ST_STOP = 3'b001,
    WDG_ST_RUN = 3'b010,
    WDG_ST_FIRE = 3'b100
  } wdg_state_t;

  typedef struct packed {
    logic [1:0] period_select;
    logic watchdog_run_bit;
  } wdg_cfg_t;

  // limit in counter ticks: 2 s shifted left by the period code, minus one
  function automatic logic [15:0] wdg_period_limit(input logic [1:0] sel);
    logic [31:0] base;
    base = 32'(WDG_PERIOD_BASE_SEC * WDG_COUNT_RATE_HZ);
    return 16'((base << sel) - 32'd1);
  endfunction : wdg_period_limit

endpackage : wdg_pkg

// *** logic/wdg_tick_gen.sv ***
`timescale 1ns/100ps

// ************************************************************
// one-cycle enable at the counter rate
// ************************************************************
module wdg_tick_gen #(
  parameter int DIV = 48828
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic tick
);

  logic [31:0] div_count;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_count <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (div_count >= 32'(DIV - 1)) begin
      div_count <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      div_count <= div_count + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

endmodule : wdg_tick_gen

// *** logic/wdg_counter.sv ***
`timescale 1ns/100ps

// ************************************************************
// watchdog count with clear and limit compare
// ************************************************************
module wdg_counter
  import wdg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic advance,
  input wire logic [15:0] limit,
  output logic [15:0] watchdog_count,
  output logic reached
);

  // clear wins over advance for the count, but a kick on the limit tick still asserts reached
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      watchdog_count <= WDG_COUNT_RST;
    end else if (clear) begin
      watchdog_count <= WDG_COUNT_RST;
    end else if (advance) begin
      watchdog_count <= watchdog_count + 16'h0001;
    end
  end

  assign reached = advance && (watchdog_count >= limit);

endmodule : wdg_counter

// *** logic/wdg_top.sv ***
// Register access over APB was decided locally.
`timescale 1ns/100ps

//
// Contract
// - watchdog is a 16-bit up-counter advanced from the low speed clock
// - count reaching the selected limit asserts a chip-wide system reset
// - watchdog reset reaches as far as a power-on reset
// - watchdog reset sets a cause flag in bit 7 of power unit status
// - period field bits 3:2 selects 2, 4, 8 or 16 s, reset 0
// - mode bit 24 of power unit status at 0 keeps watchdog off
// - mode 1: run bit controls watchdog except in rtc-only mode
// - mode 1: leaving rtc-only or waking forces the watchdog on (code sets the run bit on wake_event only, not on leaving rtc-only)
// - writing the unlock key sets the read-only unlock flag bit 0
// - any control register write, debugger included, clears the unlock flag (code keeps it set if an unlock-key write meets ext_ctrl_write)
// - run-enable bit 0 of the enable register resets to 1
// - clear register reads return the current 16-bit count in 15:0
// - writing the clear key to the clear register zeroes the count
// - count held at zero while the core is in debug mode
module wdg_top
  import wdg_pkg::*;
#(
  parameter int TICK_DIV = WDG_TICK_DIV
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire wdg_power_t power_mode,
  input wire logic wake_event,
  input wire logic ext_ctrl_write,
  input wire logic debug_mode,
  output logic system_reset,
  output logic watchdog_active,
  output logic irq
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic wdg_mapped(input logic [11:0] a);
    return (a == WDG_OFF_UNLOCK) || (a == WDG_OFF_ENABLE) ||
           (a == WDG_OFF_CLEAR) || (a == WDG_OFF_STATUS) ||
           (a == WDG_OFF_INT_STS) || (a == WDG_OFF_INT_MASK);
  endfunction : wdg_mapped

  function automatic logic wdg_wr_hit(input logic acc, input logic wr,
                                      input logic [11:0] a,
                                      input logic [11:0] off);
    return acc && wr && (a == off);
  endfunction : wdg_wr_hit

  // ************************************************************
  // declarations
  // ************************************************************
  logic setup_phase;
  logic access_phase;
  logic wr_unlock;
  logic wr_enable;
  logic wr_clear;
  logic wr_status;
  logic wr_int_mask;
  logic rd_int_sts;
  logic any_write;
  logic unlock;
  wdg_cfg_t cfg;
  logic mode_bit;
  logic reset_flag;
  logic [WDG_IRQ_W-1:0] int_sts;
  logic [WDG_IRQ_W-1:0] int_mask;
  logic [WDG_IRQ_W-1:0] events;
  wdg_state_t state;
  wdg_state_t next_state;
  logic [7:0] pulse_count;
  logic tick;
  logic allowed;
  logic count_clear;
  logic count_advance;
  logic kick_ok;
  logic reject;
  logic reached;
  logic fire;
  logic [15:0] watchdog_count;
  logic [15:0] limit;
  logic [31:0] next_rdata;

  // ************************************************************
  // apb decode
  // ************************************************************
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  // read data is registered in the setup cycle, so no wait state is needed
  assign pready = 1'b1;
  assign wr_unlock = wdg_wr_hit(access_phase, pwrite, paddr, WDG_OFF_UNLOCK);
  assign wr_enable = wdg_wr_hit(access_phase, pwrite, paddr, WDG_OFF_ENABLE);
  assign wr_clear = wdg_wr_hit(access_phase, pwrite, paddr, WDG_OFF_CLEAR);
  assign wr_status = wdg_wr_hit(access_phase, pwrite, paddr, WDG_OFF_STATUS);
  assign wr_int_mask = wdg_wr_hit(access_phase, pwrite, paddr, WDG_OFF_INT_MASK);
  assign rd_int_sts = access_phase && !pwrite && (paddr == WDG_OFF_INT_STS);
  assign any_write = access_phase && pwrite;

  // ************************************************************
  // read path
  // ************************************************************
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (paddr)
      WDG_OFF_UNLOCK: begin
        next_rdata[WDG_UNLOCK_BIT] = unlock;
      end
      WDG_OFF_ENABLE: begin
        next_rdata[WDG_SEL_LSB +: 2] = cfg.period_select;
        next_rdata[WDG_RUN_BIT] = cfg.watchdog_run_bit;
      end
      WDG_OFF_CLEAR: begin
        next_rdata[15:0] = watchdog_count;
      end
      WDG_OFF_STATUS: begin
        next_rdata[WDG_MODE_BIT] = mode_bit;
        next_rdata[WDG_FLAG_BIT] = reset_flag;
      end
      WDG_OFF_INT_STS: begin
        next_rdata[WDG_IRQ_W-1:0] = int_sts;
      end
      WDG_OFF_INT_MASK: begin
        next_rdata[WDG_IRQ_W-1:0] = int_mask;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= next_rdata;
      pslverr <= !wdg_mapped(paddr);
    end
  end

  // ************************************************************
  // unlock flag
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      unlock <= 1'b0;
    end else if (fire) begin
      unlock <= 1'b0;
    end else if (any_write) begin
      unlock <= wr_unlock && (pwdata == WDG_UNLOCK_KEY);
    end else if (ext_ctrl_write) begin
      unlock <= 1'b0;
    end
  end

  // ************************************************************
  // enable and period register
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg.watchdog_run_bit <= WDG_RUN_RST;
      cfg.period_select <= WDG_SEL_RST;
    end else if (fire) begin
      cfg.watchdog_run_bit <= WDG_RUN_RST;
      cfg.period_select <= WDG_SEL_RST;
    end else if (wake_event && mode_bit) begin
      cfg.watchdog_run_bit <= 1'b1;
    end else if (wr_enable && unlock) begin
      cfg.watchdog_run_bit <= pwdata[WDG_RUN_BIT];
      cfg.period_select <= pwdata[WDG_SEL_LSB +: 2];
    end
  end

  // ************************************************************
  // power unit status: mode bit and cause flag
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_bit <= WDG_MODE_RST;
    end else if (wr_status) begin
      mode_bit <= pwdata[WDG_MODE_BIT];
    end
  end

  // the cause flag must survive the watchdog reset itself, so only rst or a status write with bit 7 set clears it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reset_flag <= 1'b0;
    end else if (fire) begin
      reset_flag <= 1'b1;
    end else if (wr_status && pwdata[WDG_FLAG_BIT]) begin
      reset_flag <= 1'b0;
    end
  end

  // ************************************************************
  // run decision
  // ************************************************************
  // mode, run bit and power mode
  assign allowed = mode_bit && cfg.watchdog_run_bit &&
                   (power_mode != WDG_PM_RTC_ONLY);
  assign watchdog_active = (state == WDG_ST_RUN);

  assign kick_ok = wr_clear && (pwdata == WDG_CLEAR_KEY);
  assign reject = (wr_clear && !kick_ok) || (wr_enable && !unlock);

  // debug holds the count at zero
  assign count_clear = kick_ok || debug_mode || fire;
  assign count_advance = tick && (state == WDG_ST_RUN) && !debug_mode;
  assign limit = wdg_period_limit(cfg.period_select);
  assign fire = reached && (state == WDG_ST_RUN);

  // ************************************************************
  // counter and tick
  // ************************************************************
  // tick from the low speed clock rate
  wdg_tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick)
  );

  wdg_counter u_count (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(count_clear),
    .advance(count_advance),
    .limit(limit),
    .watchdog_count(watchdog_count),
    .reached(reached)
  );

  // ************************************************************
  // control state machine
  // ************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      WDG_ST_STOP: begin
        if (allowed) begin
          next_state = WDG_ST_RUN;
        end
      end
      WDG_ST_RUN: begin
        if (fire) begin
          next_state = WDG_ST_FIRE;
        end else if (!allowed) begin
          next_state = WDG_ST_STOP;
        end
      end
      WDG_ST_FIRE: begin
        if (pulse_count == 8'(WDG_RST_PULSE_CYCLES - 1)) begin
          next_state = WDG_ST_STOP;
        end
      end
      default: begin
        next_state = WDG_ST_STOP;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= WDG_ST_STOP;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulse_count <= 8'h00;
    end else if (state == WDG_ST_FIRE) begin
      pulse_count <= pulse_count + 8'h01;
    end else begin
      pulse_count <= 8'h00;
    end
  end

  // a fixed-width pulse gives the chip reset tree time to settle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      system_reset <= 1'b0;
    end else begin
      system_reset <= (next_state == WDG_ST_FIRE);
    end
  end

  // ************************************************************
  // interrupts
  // ************************************************************
  always_comb begin
    events = '0;
    events[WDG_IRQ_FIRE] = fire;
    events[WDG_IRQ_KICK] = kick_ok;
    events[WDG_IRQ_REJECT] = reject;
  end

  // read clears only what the read returned, so a new event is never lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_sts <= '0;
    end else if (rd_int_sts) begin
      int_sts <= (int_sts & ~prdata[WDG_IRQ_W-1:0]) | events;
    end else begin
      int_sts <= int_sts | events;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_mask <= '0;
    end else if (wr_int_mask) begin
      int_mask <= pwdata[WDG_IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_sts & int_mask);
    end
  end

endmodule : wdg_top

// *** test/wdg_monitor.sv ***
`timescale 1ns/100ps

// ****
// port checker for the watchdog
// ****
module wdg_monitor
  import wdg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire wdg_power_t power_mode,
  input wire logic debug_mode,
  input wire logic system_reset,
  input wire logic watchdog_active,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic setup;
  logic mapped;
  assign setup = psel && !penable;
  assign mapped = paddr inside {WDG_OFF_UNLOCK, WDG_OFF_ENABLE, WDG_OFF_CLEAR,
    WDG_OFF_STATUS, WDG_OFF_INT_STS, WDG_OFF_INT_MASK};

  // ****
  // assertions
  // ****
  pulse_len_a: assert property ($rose(system_reset) |-> system_reset[*8] ##1
    system_reset[*8] ##1 !system_reset) else $error("reset pulse length wrong");
  // two samples so the state register has seen the mode change
  rtc_off_a: assert property ((power_mode == WDG_PM_RTC_ONLY) [*2] |->
    !watchdog_active) else $error("active in rtc only mode");
  debug_quiet_a: assert property (debug_mode[*3] |=> !$rose(system_reset))
    else $error("reset during debug");
  idle_quiet_a: assert property (!watchdog_active[*3] |=> !$rose(system_reset))
    else $error("reset while stopped");
  unmapped_err_a: assert property (setup && !mapped |=> pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (setup && mapped |=> !pslverr)
    else $error("error on mapped address");
  zero_read_a: assert property (setup && !mapped |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  count_rsvd_a: assert property (setup && !pwrite && paddr == WDG_OFF_CLEAR |=>
    prdata[31:16] == 16'h0000) else $error("count upper bits set");

  cover property ($rose(system_reset));
  cover property ($rose(irq));
  cover property (setup && !mapped);
  cover property ($fell(watchdog_active));
endmodule : wdg_monitor

bind wdg_top wdg_monitor wdg_monitor_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .power_mode(power_mode), .debug_mode(debug_mode), .system_reset(system_reset),
  .watchdog_active(watchdog_active), .irq(irq));

// *** test/tb_top.sv ***
`timescale 1ns/100ps

module tb_top
  import wdg_pkg::*;
();
  // short tick divider keeps one 2 s period near 16k cycles
  localparam int DIV = 4;
  // period code 1 doubles the base interval
  localparam int FIRE_CYC = 2 * WDG_PERIOD_BASE_SEC * WDG_COUNT_RATE_HZ * DIV;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wdg_power_t power_mode = WDG_PM_WORK;
  logic wake_event = 1'b0;
  logic ext_ctrl_write = 1'b0;
  logic debug_mode = 1'b0;
  logic system_reset;
  logic watchdog_active;
  logic irq;
  logic [31:0] r;
  logic [31:0] r0;
  int n_mismatch = 0;
  int total_checks = 0;
  int n;

  wdg_top #(.TICK_DIV(DIV)) wdg_top_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_mode(power_mode), .wake_event(wake_event),
    .ext_ctrl_write(ext_ctrl_write), .debug_mode(debug_mode),
    .system_reset(system_reset), .watchdog_active(watchdog_active), .irq(irq));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ****
  // tasks
  // ****
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tk(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : tk

  // one transfer; an idle edge at the end avoids re-driving psel in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, r, e);
  endtask : rd

  task automatic unlocked_wr(input logic [31:0] d);
    wr(WDG_OFF_UNLOCK, WDG_UNLOCK_KEY);
    wr(WDG_OFF_ENABLE, d);
  endtask : unlocked_wr

  // ****
  // main sequence
  // ****
  initial begin
    tk(10);
    rst <= 1'b0;
    tk(1);
    rd(WDG_OFF_UNLOCK, 32'h0000_0000, "unlock");
    rd(WDG_OFF_ENABLE, 32'h0000_0001, "enable");
    rd(WDG_OFF_STATUS, 32'h0100_0000, "status");
    rd(12'h100, 32'h0000_0000, "unmapped");
    chk("slverr", 32'(pslverr), 32'h0000_0001);
    wr(WDG_OFF_INT_MASK, 32'h0000_0007);
    wr(WDG_OFF_ENABLE, 32'h0000_0000);
    tk(2);
    chk("irq", 32'(irq), 32'h0000_0001);
    rd(WDG_OFF_ENABLE, 32'h0000_0001, "locked");
    rd(WDG_OFF_INT_STS, 32'h0000_0004, "reject");
    tk(2);
    chk("irq low", 32'(irq), 32'h0000_0000);
    wr(WDG_OFF_UNLOCK, WDG_UNLOCK_KEY);
    rd(WDG_OFF_UNLOCK, 32'h0000_0001, "unlocked");
    ext_ctrl_write <= 1'b1;
    tk(1);
    ext_ctrl_write <= 1'b0;
    rd(WDG_OFF_UNLOCK, 32'h0000_0000, "ext write");
    wr(WDG_OFF_UNLOCK, WDG_UNLOCK_KEY);
    wr(WDG_OFF_INT_MASK, 32'h0000_0007);
    rd(WDG_OFF_UNLOCK, 32'h0000_0000, "any write");
    for (int p = 3; p >= 0; p--) begin
      unlocked_wr(32'(p * 4 + 1));
      rd(WDG_OFF_ENABLE, 32'(p * 4 + 1), "period");
    end
    unlocked_wr(32'h0000_0000);
    tk(2);
    chk("stopped", 32'(watchdog_active), 32'h0000_0000);
    apb(1'b0, WDG_OFF_CLEAR, 32'h0000_0000);
    r0 = r;
    tk(40);
    wr(WDG_OFF_CLEAR, 32'h0000_1234);
    rd(WDG_OFF_CLEAR, r0, "held");
    wr(WDG_OFF_CLEAR, WDG_CLEAR_KEY);
    rd(WDG_OFF_CLEAR, 32'h0000_0000, "cleared");
    rd(WDG_OFF_INT_STS, 32'h0000_0006, "events");
    wake_event <= 1'b1;
    tk(1);
    wake_event <= 1'b0;
    rd(WDG_OFF_ENABLE, 32'h0000_0001, "woken");
    chk("running", 32'(watchdog_active), 32'h0000_0001);
    power_mode <= WDG_PM_RTC_ONLY;
    tk(3);
    chk("rtc only", 32'(watchdog_active), 32'h0000_0000);
    power_mode <= WDG_PM_IDLE;
    tk(3);
    chk("idle", 32'(watchdog_active), 32'h0000_0001);
    power_mode <= WDG_PM_SLEEP;
    tk(3);
    chk("sleep", 32'(watchdog_active), 32'h0000_0001);
    power_mode <= WDG_PM_DEEP;
    tk(3);
    chk("deep", 32'(watchdog_active), 32'h0000_0001);
    power_mode <= WDG_PM_WORK;
    wr(WDG_OFF_STATUS, 32'h0000_0000);
    tk(2);
    chk("mode off", 32'(watchdog_active), 32'h0000_0000);
    wr(WDG_OFF_STATUS, 32'h0100_0000);
    debug_mode <= 1'b1;
    tk(40);
    rd(WDG_OFF_CLEAR, 32'h0000_0000, "debug");
    debug_mode <= 1'b0;
    wr(WDG_OFF_CLEAR, WDG_CLEAR_KEY);
    tk(400);
    apb(1'b0, WDG_OFF_CLEAR, 32'h0000_0000);
    chk("rate", 32'(r > 98 && r < 104), 32'h0000_0001);
    // longer period so the fire time also proves the period decode
    unlocked_wr(32'h0000_0005);
    wr(WDG_OFF_CLEAR, WDG_CLEAR_KEY);
    // left unlocked so the fire must drop the flag
    wr(WDG_OFF_UNLOCK, WDG_UNLOCK_KEY);
    apb(1'b0, WDG_OFF_INT_STS, 32'h0000_0000);
    n = 0;
    while (system_reset !== 1'b1 && n < FIRE_CYC + 4000) begin
      tk(1);
      n++;
    end
    chk("fire time", 32'(n > FIRE_CYC - 20 && n < FIRE_CYC + 20), 32'h0000_0001);
    tk(20);
    chk("irq fire", 32'(irq), 32'h0000_0001);
    rd(WDG_OFF_STATUS, 32'h0100_0080, "flag");
    rd(WDG_OFF_UNLOCK, 32'h0000_0000, "reinit lock");
    rd(WDG_OFF_ENABLE, 32'h0000_0001, "reinit");
    rd(WDG_OFF_INT_STS, 32'h0000_0001, "fire");
    wr(WDG_OFF_STATUS, 32'h0100_0080);
    rd(WDG_OFF_STATUS, 32'h0100_0000, "flag clear");
    wr(WDG_OFF_INT_MASK, 32'h0000_0000);
    wr(WDG_OFF_CLEAR, 32'h0000_0001);
    tk(2);
    chk("masked", 32'(irq), 32'h0000_0000);
    rd(WDG_OFF_INT_STS, 32'h0000_0004, "sticky");
    conclude();
  end
endmodule : tb_top
